// ==== asm_capture_model.sv ====
/*
  Capture-side model: holds sample words and records channel 0 link history.
  Assumes the sample clock; words stay fixed so any frame phase can be matched.
*/
`default_nettype none

module asm_capture_model
  import asm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [CHANNELS-1:0] i_lane0,
  input wire logic [CHANNELS-1:0] i_lane1,
  input wire logic i_bclk,
  input wire logic i_fclk,
  output logic [CHANNELS-1:0][serial_word_length-1:0] o_sample,
  output logic [31:0] o_h0,
  output logic [31:0] o_h1,
  output logic [31:0] o_hf,
  output logic [31:0] o_hb
);
  timeunit 1ns;
  timeprecision 100ps;
  // One word per channel, distinct so lanes cannot alias
  always_comb
  begin
    for (int c = 0; c < CHANNELS; c++)
      o_sample[c] = 16'hc5a3 + 16'(c);
  end

  // Newest sample in bit 0; two frames of the longest kind fit
  always_ff @(posedge i_ref_clk)
  begin
    o_h0 <= {o_h0[30:0], i_lane0[0]};
    o_h1 <= {o_h1[30:0], i_lane1[0]};
    o_hf <= {o_hf[30:0], i_fclk};
    o_hb <= {o_hb[30:0], i_bclk};
  end

endmodule : asm_capture_model

`default_nettype wire

// ==== asm_pkg.sv ====
/*
  Shared constants for the converter serial output mode and digital reset block.
  Assumes one sample-clock domain; every file imports this package whole.
*/
`default_nettype none

package asm_pkg;

  // Register map, 13-bit serial-port addresses
  localparam logic [12:0] ADDR_PWR_MODE = 13'h008; // Power-mode register
  localparam logic [12:0] ADDR_FMT_CTRL = 13'h021; // serial_output_format_ctrl

  // Reset values
  localparam logic [7:0] FMT_RESET = 8'h30; // Two-lane DDR bytewise, 1x frame
  localparam logic [1:0] PWR_RESET = 2'h0;  // Normal operation

  // Format field positions
  localparam int FMT_ONE_LANE_BIT = 6; // One lane per channel, wordwise
  localparam int FMT_DDR_BIT = 5;      // DDR signalling
  localparam int FMT_BYTE_BIT = 4;     // Bytewise ordering
  localparam int FMT_DOUBLE_BIT = 2;   // Double frame rate

  // Power-mode field positions and codes
  localparam int PWR_BUSY_BIT = 7;   // Read only: init or settle running
  localparam int PWR_PIN_FN_BIT = 5; // Stored pin-function option
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam logic [1:0] PWR_DOWN = 2'h1;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_DRESET = 2'h3;

  // Serial word and link geometry
  localparam int CHANNELS = 4;
  localparam int serial_word_length = 16; // Bits per sample word
  localparam int SLOT_W = 4;              // Clock slots per frame, at most 16
  localparam logic [SLOT_W-1:0] FRAME_SHORT = 4'h8; // Two-lane DDR frame
  localparam logic [SLOT_W-1:0] FRAME_LONG = 4'hf;  // Last slot of 16-slot frame
  localparam logic [SLOT_W-1:0] FRAME_LAST_SHORT = 4'h7;

  // Serial control port framing
  localparam int INSTR_BITS = 16;
  localparam int DATA_BITS = 8;
  localparam int SPI_CNT_W = 5;
  localparam logic [SPI_CNT_W-1:0] SPI_DATA_FIRST = 5'h10; // First data bit index
  localparam logic [SPI_CNT_W-1:0] SPI_LAST = 5'h17;       // Last data bit index
  localparam logic [SPI_CNT_W-1:0] SPI_DONE = 5'h18;       // Beyond the transfer
  localparam int INSTR_RW_BIT = 15;                        // 1 = read

  // Settle time after reset release, in sample clock cycles
  localparam int RESUME_CYCLES_DEF = 2900000;
  localparam int WAIT_W = 22;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_INIT = 4'h1,   // Power-up initialization
    ST_RUN = 4'h2,    // Normal conversion
    ST_HALT = 4'h4,   // Power-down, standby or digital reset held
    ST_SETTLE = 4'h8  // Waiting after reset release
  } asm_state_e;

endpackage : asm_pkg

`default_nettype wire

// ==== asm_spi_slave.sv ====
/*
  Three-wire serial control port slave, oversampled by the sample clock.
  Assumes SCLK, CSB and SDIO are asynchronous pins; read data comes from the parent
  combinationally from o_addr.
*/
`default_nettype none

module asm_spi_slave
  import asm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  input wire logic [DATA_BITS-1:0] i_rdata,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic o_wr,
  output logic [12:0] o_addr,
  output logic [DATA_BITS-1:0] o_wdata
);

  // Synchronisers: stage a feeds stage b only
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_prev; // Delayed sclk for edge detection
  logic [SPI_CNT_W-1:0] cnt; // Bit position in transfer
  logic [INSTR_BITS-1:0] instr; // Instruction shift register
  logic [DATA_BITS-1:0] data; // Write data shift register
  logic sdo; // Read bit driven out
  logic sdo_oe; // Read drive enable
  logic wr; // One-cycle write strobe
  logic [SPI_CNT_W-1:0] next_cnt;
  logic [INSTR_BITS-1:0] next_instr;
  logic [DATA_BITS-1:0] next_data;
  logic next_sdo;
  logic next_sdo_oe;
  logic next_wr;
  logic rise;
  logic fall;
  logic [SPI_CNT_W-1:0] rd_idx;

  assign rise = sync_b[0] & ~sclk_prev;
  assign fall = ~sync_b[0] & sclk_prev;
  assign rd_idx = SPI_LAST - cnt;

  // Next state of the shifter
  always_comb
  begin
    next_cnt = cnt;
    next_instr = instr;
    next_data = data;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_wr = 1'b0;
    if (sync_b[1])
    begin
      // Chip select idle: abort any transfer
      next_cnt = '0;
      next_sdo_oe = 1'b0;
    end
    else if (rise && cnt < SPI_DONE)
    begin
      // Capture on rising edge, MSB first
      if (cnt < SPI_DATA_FIRST)
        next_instr = {instr[INSTR_BITS-2:0], sync_b[2]};
      else
        next_data = {data[DATA_BITS-2:0], sync_b[2]};
      next_cnt = cnt + 1'b1;
      // Write lands on last data bit, no wait needed before the next one [RULE10]
      if (cnt == SPI_LAST && !instr[INSTR_RW_BIT])
        next_wr = 1'b1;
    end
    else if (fall)
    begin
      // Read bits launched on falling edge
      if (instr[INSTR_RW_BIT] && cnt >= SPI_DATA_FIRST && cnt < SPI_DONE)
      begin
        next_sdo_oe = 1'b1;
        next_sdo = i_rdata[rd_idx[2:0]];
      end
      else
        next_sdo_oe = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync_a <= 3'h2;
      sync_b <= 3'h2;
      sclk_prev <= 1'b0;
      cnt <= '0;
      instr <= '0;
      data <= '0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      wr <= 1'b0;
    end
    else
    begin
      sync_a <= {i_sdio, i_csb_n, i_sclk};
      sync_b <= sync_a;
      sclk_prev <= sync_b[0];
      cnt <= next_cnt;
      instr <= next_instr;
      data <= next_data;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      wr <= next_wr;
    end
  end

  assign o_sdio = sdo;
  assign o_sdio_oe = sdo_oe;
  assign o_wr = wr;
  assign o_addr = instr[12:0];
  assign o_wdata = data;

endmodule : asm_spi_slave

`default_nettype wire

// ==== asm_top.sv ====
/*
  Output serializer for a four-channel 16-bit converter, with its register port
  and power-up / digital reset sequencer.
  Assumes one sample clock drives everything; the serial control pins are
  asynchronous and oversampled; each clock is one serial slot of the link.
*/
// How it works
// RULE1 - 0x30: two-lane DDR bytewise, 4x bit clock
// RULE2 - 0x20: two-lane DDR bitwise, 4x bit clock
// RULE3 - 0x10: two-lane SDR bytewise, 8x bit clock
// RULE4 - 0x00: two-lane SDR bitwise, 8x bit clock
// RULE5 - Bit 2 set doubles the frame rate; the code ignores it in one-lane mode
// RULE6 - 0x40: one DDR lane, wordwise, 8x clock
// RULE7 - Power-up runs an initialization sequence first
// RULE8 - Controller supplies stable clock, else resets again
// RULE9 - Digital reset: write 0x03 then 0x00 to 0x08
// RULE10 - Release write may follow immediately
// RULE11 - Resume only after 2.9 million cycles
// RULE12 - Zero sample data while reset completes
// RULE13 - Controller keeps serial port quiet when critical
// RULE14 - Mode 11 resets datapath, keeps port; 00 runs
`default_nettype none

module asm_top
  import asm_pkg::*;
#(
  parameter int RESUME_CYCLES = RESUME_CYCLES_DEF // Settle and init length
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  output logic o_sdio,
  output logic o_sdio_oe,
  input wire logic [CHANNELS-1:0][serial_word_length-1:0] i_sample,
  output logic o_sample_take,
  output logic [CHANNELS-1:0] o_lane0,
  output logic [CHANNELS-1:0] o_lane1,
  output logic o_bit_clock_out,
  output logic o_frame_clock_out,
  output logic o_busy
);

  localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(RESUME_CYCLES - 1);

  // Pick the bit for one lane at one slot
  function automatic logic lane_bit(input logic [serial_word_length-1:0] word,
                                    input logic [SLOT_W-1:0] k,
                                    input logic one_lane,
                                    input logic bytewise,
                                    input logic upper);
    logic [SLOT_W-1:0] idx;
    idx = '0;
    if (one_lane)
      idx = SLOT_W'(serial_word_length - 1) - k; // Whole word MSB first [RULE6]
    else if (bytewise)
      idx = upper ? FRAME_LONG - k : FRAME_LAST_SHORT - k; // Byte per lane [RULE1] [RULE3]
    else
      idx = upper ? FRAME_LONG - {k[2:0], 1'b0} : (FRAME_LONG - 1'b1) - {k[2:0], 1'b0}; // [RULE2] [RULE4]
    return word[idx];
  endfunction : lane_bit

  // Register port
  logic spi_wr; // Write strobe
  logic [12:0] spi_addr; // Current address
  logic [DATA_BITS-1:0] spi_wdata; // Write data
  logic [DATA_BITS-1:0] rdata; // Read mux

  // Stored controls
  logic [DATA_BITS-1:0] fmt; // serial_output_format_ctrl
  logic [1:0] pwr_mode; // Power mode field
  logic pin_fn; // Stored pin-function option
  logic [DATA_BITS-1:0] next_fmt;
  logic [1:0] next_pwr_mode;
  logic next_pin_fn;

  // Sequencer
  asm_state_e state; // Current sequencer state
  asm_state_e next_state;
  logic [WAIT_W-1:0] wait_cnt; // Init and settle counter
  logic [WAIT_W-1:0] next_wait_cnt;

  // Serializer
  logic [SLOT_W-1:0] slot; // Clock slot within frame
  logic [SLOT_W-1:0] next_slot;
  logic [CHANNELS-1:0][serial_word_length-1:0] word; // Words being sent
  logic [CHANNELS-1:0][serial_word_length-1:0] next_word;
  logic [CHANNELS-1:0] lane0;
  logic [CHANNELS-1:0] lane1;
  logic [CHANNELS-1:0] next_lane0;
  logic [CHANNELS-1:0] next_lane1;
  logic bit_clock_out;
  logic frame_clock_out;
  logic next_dco;
  logic next_fco;
  logic take;
  logic next_take;
  logic [DATA_BITS-1:0] fmt_live; // Format in force, swapped only at a frame end
  logic [DATA_BITS-1:0] next_fmt_live;
  logic [CHANNELS-1:0] lane0_bits; // Per-channel lane bit selection
  logic [CHANNELS-1:0] lane1_bits;

  // Decoded format fields
  logic one_lane;
  logic ddr;
  logic bytewise;
  logic dbl;
  logic [SLOT_W-1:0] last_slot; // Final slot of a frame
  logic [SLOT_W-1:0] half; // Half-frame length
  logic [SLOT_W-1:0] bit_k; // Bit position on each lane
  logic clocks_on; // Link clocks running
  logic data_on; // Real samples allowed on link

  // Decoded from the live copy, so no frame ever mixes two formats
  assign one_lane = fmt_live[FMT_ONE_LANE_BIT];
  assign ddr = fmt_live[FMT_DDR_BIT] | one_lane; // One-lane mode is always DDR [RULE6]
  assign bytewise = fmt_live[FMT_BYTE_BIT];
  assign dbl = fmt_live[FMT_DOUBLE_BIT] & ~one_lane;

  // Two-lane DDR packs 8 bits into 8 slots: 4 bit-clock periods per sample.
  // SDR and one-lane need 16 slots: 8 bit-clock periods per sample.
  assign last_slot = (ddr && !one_lane) ? FRAME_LAST_SHORT : FRAME_LONG; // [RULE1] [RULE3] [RULE6]
  assign half = (ddr && !one_lane) ? (FRAME_SHORT >> 1) : FRAME_SHORT;
  assign bit_k = ddr ? slot : (slot >> 1); // SDR holds each bit two slots [RULE3] [RULE4]

  // Datapath clocks stop in halt; they run through settle with zero data
  assign clocks_on = (state == ST_RUN) || (state == ST_SETTLE); // [RULE14]
  assign data_on = (state == ST_RUN); // [RULE12]

  asm_spi_slave u_spi (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_sclk(i_sclk),
    .i_csb_n(i_csb_n),
    .i_sdio(i_sdio),
    .i_rdata(rdata),
    .o_sdio(o_sdio),
    .o_sdio_oe(o_sdio_oe),
    .o_wr(spi_wr),
    .o_addr(spi_addr),
    .o_wdata(spi_wdata)
  );

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata = '0;
    case (spi_addr)
      ADDR_PWR_MODE:
      begin
        rdata[1:0] = pwr_mode;
        rdata[PWR_PIN_FN_BIT] = pin_fn;
        rdata[PWR_BUSY_BIT] = o_busy; // Shows sequencer still waiting
      end
      ADDR_FMT_CTRL: rdata = fmt;
      default: rdata = '0;
    endcase
  end

  // Register writes; the port itself is never reset by mode 11
  always_comb
  begin
    next_fmt = fmt;
    next_pwr_mode = pwr_mode;
    next_pin_fn = pin_fn;
    if (spi_wr)
    begin
      case (spi_addr)
        ADDR_FMT_CTRL: next_fmt = spi_wdata; // Steers the serializer [RULE1]
        ADDR_PWR_MODE:
        begin
          next_pwr_mode = spi_wdata[1:0]; // 11 asserts, 00 releases reset [RULE9] [RULE14]
          next_pin_fn = spi_wdata[PWR_PIN_FN_BIT];
        end
        default: next_fmt = fmt; // Writes elsewhere ignored
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fmt <= FMT_RESET;
      pwr_mode <= PWR_RESET;
      pin_fn <= 1'b0;
    end
    else
    begin
      fmt <= next_fmt;
      pwr_mode <= next_pwr_mode;
      pin_fn <= next_pin_fn;
    end
  end

  // Sequencer: init after power-up, halt on any non-normal mode, settle after release
  always_comb
  begin
    next_state = state;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_INIT:
      begin
        // Bias and register setup time; a clean clock is assumed here [RULE7] [RULE8]
        if (pwr_mode != PWR_NORMAL)
        begin
          next_state = ST_HALT;
          next_wait_cnt = '0;
        end
        else if (wait_cnt == WAIT_LAST)
          next_state = ST_RUN;
        else
          next_wait_cnt = wait_cnt + 1'b1;
      end
      ST_RUN:
      begin
        if (pwr_mode != PWR_NORMAL)
          next_state = ST_HALT; // [RULE14]
      end
      ST_HALT:
      begin
        next_wait_cnt = '0;
        if (pwr_mode == PWR_NORMAL)
          next_state = ST_SETTLE; // Release starts the long wait [RULE11]
      end
      ST_SETTLE:
      begin
        if (pwr_mode != PWR_NORMAL)
        begin
          next_state = ST_HALT; // A new reset restarts the wait
          next_wait_cnt = '0;
        end
        else if (wait_cnt == WAIT_LAST)
          next_state = ST_RUN; // One cycle in halt plus RESUME_CYCLES of settle after release [RULE11]
        else
          next_wait_cnt = wait_cnt + 1'b1;
      end
      default:
      begin
        next_state = ST_INIT;
        next_wait_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_INIT;
      wait_cnt <= '0;
    end
    else
    begin
      state <= next_state;
      wait_cnt <= next_wait_cnt;
    end
  end

  // Serializer: slot counter, sample capture and lane bits
  always_comb
  begin
    next_slot = slot;
    next_word = word;
    next_take = 1'b0;
    next_lane0 = '0;
    next_lane1 = '0;
    next_dco = 1'b0;
    next_fco = 1'b0;
    next_fmt_live = fmt_live;
    if (!clocks_on)
    begin
      // Halted: counter cleared, words flushed, link quiet [RULE14]
      next_slot = '0;
      next_word = '0;
    end
    else
    begin
      // Frame boundary: load next sample set, zeros while settling [RULE12]
      if (slot >= last_slot)
      begin
        next_slot = '0;
        next_word = data_on ? i_sample : '0;
        next_take = data_on;
        next_fmt_live = fmt; // A new format starts on a whole frame [RULE5]
      end
      else
        next_slot = slot + 1'b1;
      // Bit clock toggles every slot: DDR edge per bit, SDR period per bit
      next_dco = slot[0]; // [RULE1] [RULE3] [RULE6]
      // Frame clock: one pulse per frame, or two in double mode [RULE5]
      if (dbl)
        next_fco = (slot & (half - 1'b1)) < (half >> 1);
      else
        next_fco = slot < half;
    end
    // Lane bits for every channel
    for (int c = 0; c < CHANNELS; c++)
    begin
      next_lane1[c] = lane1_bits[c];
      next_lane0[c] = lane0_bits[c];
    end
  end

  // Per-channel lane bit selection
  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc++)
    begin : g_chan
      // Second lane carries the high byte or odd bits; idle in one-lane mode
      assign lane1_bits[gc] = clocks_on && !one_lane &&
                              lane_bit(word[gc], bit_k, one_lane, bytewise, 1'b1);
      assign lane0_bits[gc] = clocks_on && lane_bit(word[gc], bit_k, one_lane, bytewise, 1'b0);
    end
  endgenerate

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      slot <= '0;
      word <= '0;
      take <= 1'b0;
      lane0 <= '0;
      lane1 <= '0;
      bit_clock_out <= 1'b0;
      frame_clock_out <= 1'b0;
      fmt_live <= FMT_RESET;
    end
    else
    begin
      slot <= next_slot;
      word <= next_word;
      take <= next_take;
      lane0 <= next_lane0;
      lane1 <= next_lane1;
      bit_clock_out <= next_dco;
      frame_clock_out <= next_fco;
      fmt_live <= next_fmt_live;
    end
  end

  // Outputs from flip-flops, except o_busy, which is decoded from state
  assign o_lane0 = lane0;
  assign o_lane1 = lane1;
  assign o_bit_clock_out = bit_clock_out;
  assign o_frame_clock_out = frame_clock_out;
  assign o_sample_take = take;
  assign o_busy = (state == ST_INIT) || (state == ST_SETTLE); // Still initializing or settling after reset release [RULE7] [RULE11]

endmodule : asm_top

`default_nettype wire

// ==== asm_top_sva.sv ====
/*
  Port checker for asm_top: link framing, settle and port idle behaviour.
  Assumes one sample clock and is bound onto asm_top.
*/
`default_nettype none

module asm_top_sva
  import asm_pkg::*;
#(
  parameter int RESUME_CYCLES = 20 // Settle length under test
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_csb_n,
  input wire logic o_sdio_oe,
  input wire logic o_sample_take,
  input wire logic [CHANNELS-1:0] o_lane0,
  input wire logic [CHANNELS-1:0] o_lane1,
  input wire logic o_bit_clock_out,
  input wire logic o_frame_clock_out,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  logic ran; // Power-up init has ended once
  logic next_ran;
  int busy_cnt; // Consecutive busy cycles
  int next_busy_cnt;

  // Later busy spells are settles, not init
  always_comb
  begin
    next_ran = ran | ~o_busy;
    next_busy_cnt = o_busy ? busy_cnt + 1 : 0;
  end

  // Helper registers
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ran <= 1'b0;
      busy_cnt <= 0;
    end
    else
    begin
      ran <= next_ran;
      busy_cnt <= next_busy_cnt;
    end
  end

  a_take_spacing: assert property (o_sample_take |=> !o_sample_take [*7])
    else $error("take pulses closer than a frame");
  a_take_run: assert property (o_sample_take |-> !$past(o_busy))
    else $error("take pulsed while busy");
  a_settle_zero: assert property ((ran && o_busy) |-> (o_lane0 == '0 && o_lane1 == '0))
    else $error("lane data during settle");
  a_bitclk_half: assert property (o_bit_clock_out |=> !o_bit_clock_out)
    else $error("bit clock high two cycles");
  a_settle_len: assert property ($fell(o_busy) |-> (busy_cnt >= RESUME_CYCLES - 1 && busy_cnt <= RESUME_CYCLES + 1))
    else $error("busy length wrong");
  a_port_idle: assert property (i_csb_n [*6] |-> !o_sdio_oe)
    else $error("sdio driven while deselected");
  a_halt_quiet: assert property ((!o_busy && !o_bit_clock_out) [*3] |->
    (o_lane0 == '0 && o_lane1 == '0 && !o_frame_clock_out))
    else $error("link active with stopped bit clock");
  a_frame_even: assert property ($rose(o_frame_clock_out) |-> !o_bit_clock_out)
    else $error("frame starts on odd slot");

endmodule : asm_top_sva

bind asm_top asm_top_sva #(.RESUME_CYCLES(RESUME_CYCLES)) u_asm_top_sva (
  .i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst),
  .i_csb_n(i_csb_n),
  .o_sdio_oe(o_sdio_oe),
  .o_sample_take(o_sample_take),
  .o_lane0(o_lane0),
  .o_lane1(o_lane1),
  .o_bit_clock_out(o_bit_clock_out),
  .o_frame_clock_out(o_frame_clock_out),
  .o_busy(o_busy)
);

`default_nettype wire

// ==== asm_top_tb_top.sv ====
/*
  Self-checking bench for asm_top: register port, output formats, digital reset.
  Assumes a short settle parameter and a pulled-down sdio wire.
*/
`default_nettype none

module asm_top_tb_top
  import asm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int RC = 60; // Shortened init and settle count
  logic clk, rst, sclk, csb_n, tb_sdio, tb_oe, o_sdio, o_oe, take, bclk, fclk, busy;
  wire logic sdio_w = o_oe ? o_sdio : (tb_oe ? tb_sdio : 1'b0); // Pull-down when released
  logic [CHANNELS-1:0][serial_word_length-1:0] sample;
  logic [CHANNELS-1:0] lane0, lane1;
  logic [31:0] h0, h1, hf, hb;
  int err_count, samples_checked, cycles;
  logic [7:0] rv;

  asm_top #(.RESUME_CYCLES(RC)) u_asm_top (.i_ref_clk(clk), .i_sys_rst(rst), .i_sclk(sclk),
    .i_csb_n(csb_n), .i_sdio(sdio_w), .o_sdio(o_sdio), .o_sdio_oe(o_oe), .i_sample(sample),
    .o_sample_take(take), .o_lane0(lane0), .o_lane1(lane1), .o_bit_clock_out(bclk),
    .o_frame_clock_out(fclk), .o_busy(busy));
  asm_capture_model u_asm_capture_model (.i_ref_clk(clk), .i_lane0(lane0), .i_lane1(lane1),
    .i_bclk(bclk), .i_fclk(fclk), .o_sample(sample), .o_h0(h0), .o_h1(h1), .o_hf(hf), .o_hb(hb));

  // Sample clock, 8 ns
  always #4 clk = ~clk;

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // One 24-bit frame, MSB first, 125 ns serial clock
  task automatic spi_xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd, output logic [7:0] r);
    logic [23:0] w;
    w = {rd, 2'b00, a, wd};
    r = 8'h00;
    @(negedge clk);
    #0.3; // The 125 ns grid would otherwise land pin edges on clock edges
    csb_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      tb_oe = !(rd && i < 8); // Hand the pin over for read data
      tb_sdio = w[i];
      #62.5;
      if (rd && i < 8)
        r[i] = sdio_w;
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
    end
    #62.5;
    csb_n = 1'b1;
    tb_oe = 1'b0;
    repeat (8) @(negedge clk);
  endtask : spi_xfer

  task automatic wreg(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] v;
    spi_xfer(1'b0, a, d, v);
  endtask : wreg

  task automatic wait_idle();
    for (int k = 0; k < 4 * RC && busy !== 1'b0; k++)
      @(negedge clk);
    check_val({7'h0, busy}, 8'h00);
  endtask : wait_idle

  // Look for one whole frame of the expected stream in the history
  task automatic check_stream(input logic [7:0] f);
    logic [15:0] w;
    logic one, byt, dbl, hit, ok, l0, l1, fc;
    int n, b;
    w = 16'hc5a3;
    one = f[6];
    byt = f[4];
    dbl = f[2] & ~one;
    n = (f[5] && !one) ? 8 : 16;
    hit = 1'b0;
    repeat (40) @(negedge clk); // Serial port held quiet meanwhile
    for (int off = 0; off <= 32 - n; off++)
    begin
      ok = 1'b1;
      for (int s = 0; s < n; s++)
      begin
        b = (n == 8) ? s : s / 2;
        l0 = one ? w[15-s] : (byt ? w[7-b] : w[14-2*b]);
        l1 = one ? 1'b0 : (byt ? w[15-b] : w[15-2*b]);
        fc = (n == 8) ? (dbl ? (s % 4 < 2) : (s < 4)) : (dbl ? (s % 8 < 4) : (s < 8));
        ok = ok && h0[off+n-1-s] === l0 && h1[off+n-1-s] === l1;
        ok = ok && hf[off+n-1-s] === fc && hb[off+n-1-s] === (s % 2 == 1);
      end
      hit = hit | ok;
    end
    check_val({7'h0, hit}, 8'h01);
  endtask : check_stream

  task automatic t_powerup();
    check_val({7'h0, busy}, 8'h01);
    wait_idle();
    spi_xfer(1'b1, ADDR_FMT_CTRL, 8'h00, rv);
    check_val(rv, 8'h30);
    spi_xfer(1'b1, ADDR_PWR_MODE, 8'h00, rv);
    check_val(rv & 8'h03, 8'h00);
    spi_xfer(1'b1, 13'h0ff, 8'h00, rv);
    check_val(rv, 8'h00);
    check_stream(8'h30);
  endtask : t_powerup

  task automatic t_formats();
    logic [7:0] fmts [8] = '{8'h20, 8'h10, 8'h00, 8'h34, 8'h24, 8'h14, 8'h04, 8'h40};
    foreach (fmts[i])
    begin
      wreg(ADDR_FMT_CTRL, fmts[i]);
      spi_xfer(1'b1, ADDR_FMT_CTRL, 8'h00, rv);
      check_val(rv, fmts[i]);
      check_stream(fmts[i]);
    end
  endtask : t_formats

  // Digital reset, release as the very next instruction
  task automatic t_dreset();
    wreg(ADDR_PWR_MODE, 8'h03);
    check_val({lane0, lane1}, 8'h00);
    check_val({7'h0, busy}, 8'h00);
    wreg(ADDR_PWR_MODE, 8'h00);
    check_val({7'h0, busy}, 8'h01);
    check_val({lane0, lane1}, 8'h00);
    wait_idle();
    spi_xfer(1'b1, ADDR_FMT_CTRL, 8'h00, rv);
    check_val(rv, 8'h40);
    check_stream(8'h40);
  endtask : t_dreset

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    sclk = 1'b0;
    csb_n = 1'b1;
    tb_sdio = 1'b0;
    tb_oe = 1'b0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_powerup();
    t_formats();
    t_dreset();
    give_verdict();
  end

endmodule : asm_top_tb_top

`default_nettype wire
